//--- core/waveform_store_pkg.sv
// Package of constants, types and carriers for the waveform store block
// What this block does
// - Late placement puts 7/8 of record before trigger; early puts 7/8 after.
// - A menu value may place the trigger at any record sample.
// - Accumulated peak and peak detect modes are selectable in storage mode.
// - Sweep count limit is programmable; power-up value is unlimited.
// - Newest acquisition weight defaults to one quarter at power-up.
// - Weight is a power of two from one half to 1/256.
// - Average is normalised so the result keeps the input amplitude scale.
// - Averaging stops on a mode change or when the sweep limit is hit.
// - After the limit the averaged record stays shown until mode or a data-affecting control changes.
// - A data-affecting control change restarts averaging at full amplitude.
// - Arm save then press a display toggle to overwrite that reference.
// - The saved record goes to the slot of the pressed toggle.
// - A toggle press without arming toggles the display of that slot on or off.
// - Horizontal scale up to ten times only when the reference holds cursor.
// - No vertical expand at 2 mV/div, no compress at 5 V/div.
// - No ground capture with baseline beyond five divisions from centre.
// - In summed mode ground capture needs both couplings at ground.
// - Stored ground shows as a marked dot at the first record sample.
// - Two cursors; select swaps the active one; moves touch only active.
// - Uncalibrated variable gain turns the voltage readout into a ratio.
// - Time readout is difference or reciprocal; difference at power-up.
// - Voltage readout is unsigned, measured from the inactive cursor.
package waveform_store_pkg;
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_TRIG = 8'h04;
	localparam logic [7:0] ADDR_AVG = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_CURSOR = 8'h10;
	localparam logic [7:0] ADDR_REF_CMD = 8'h14;
	localparam logic [7:0] ADDR_REF_DATA = 8'h18;
	localparam logic [7:0] ADDR_SCALE = 8'h1c;
	localparam logic [7:0] ADDR_GROUND = 8'h20;
	localparam logic [7:0] ADDR_READOUT = 8'h24;
	localparam logic [7:0] ADDR_TIME = 8'h28;
	localparam logic [7:0] ADDR_CHANGE = 8'h2c;
	localparam logic [3:0] WEIGHT_SHIFT_RST = 4'h2;
	localparam logic [3:0] WEIGHT_SHIFT_MIN = 4'h1;
	localparam logic [3:0] WEIGHT_SHIFT_MAX = 4'h8;
	localparam logic [15:0] SWEEP_LIMIT_RST = 16'h0000;
	localparam int TRIG_LATE_EIGHTHS = 7;
	localparam int TRIG_EARLY_EIGHTHS = 1;
	localparam logic [3:0] HSCALE_MAX = 4'ha;
	localparam logic [3:0] VDIV_MOST = 4'h0;
	localparam logic [3:0] VDIV_LEAST = 4'ha;
	localparam logic [3:0] VSTEP_MAX = 4'h3;
	localparam logic signed [7:0] GROUND_WINDOW = 8'sh32;
	localparam logic [31:0] RECIP_NUM = 32'h000f4240;

	typedef enum logic [2:0] {
		MODE_SAMPLE = 3'b000,
		MODE_ACC_PEAK = 3'b001,
		MODE_PEAK_DET = 3'b010,
		MODE_AVERAGE = 3'b011
	} acq_mode_type;

	typedef enum logic [1:0] {
		TRIG_LATE = 2'b00,
		TRIG_EARLY = 2'b01,
		TRIG_CUSTOM = 2'b10
	} trig_place_type;

	typedef enum logic {
		COPY_IDLE = 1'b0,
		COPY_RUN = 1'b1
	} copy_state_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_type;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_rsp_type;

	typedef struct packed {
		logic valid;
		logic first;
		logic [15:0] value;
		logic [15:0] peak;
	} sample_type;

	typedef struct packed {
		logic valid;
		logic [15:0] index;
		logic [15:0] value;
		logic ground_dot;
	} display_type;
endpackage

//--- core/waveform_store_average_cursor.sv
// Acquisition store, averaging, reference memory, ground and cursor readouts
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
module waveform_store_average_cursor #(
	parameter int RECORD_LEN = 1024
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire waveform_store_pkg::wb_req_type wb_req,
	output waveform_store_pkg::wb_rsp_type wb_rsp,
	input wire waveform_store_pkg::sample_type sample_in,
	output waveform_store_pkg::display_type display_out,
	output logic [15:0] trigger_index
);
	import waveform_store_pkg::*;
	localparam int AW = $clog2(RECORD_LEN);
	localparam logic [15:0] LATE_POS = 16'(RECORD_LEN * TRIG_LATE_EIGHTHS / 8);
	localparam logic [15:0] EARLY_POS = 16'(RECORD_LEN * TRIG_EARLY_EIGHTHS / 8);
	localparam logic [15:0] LAST_POS = 16'(RECORD_LEN - 1);

	if (RECORD_LEN < 8 || RECORD_LEN > 32768 ||
		(RECORD_LEN & (RECORD_LEN - 1)) != 0) begin : g_bad_len
		$error("RECORD_LEN must be a power of two from 8 to 32768");
	end

	logic [15:0] acq_mem [RECORD_LEN];
	logic [15:0] ref_mem [2][RECORD_LEN];
	acq_mode_type acq_mode_q;
	trig_place_type trig_place_q;
	logic time_recip_q;
	logic [15:0] trig_custom_q;
	logic [3:0] weight_shift_q;
	logic [15:0] sweep_limit_q, sweeps_done_q;
	logic sweep_active_q, first_sweep_q;
	logic [AW-1:0] idx_q;
	logic [15:0] c0_q, c1_q;
	logic active_q, on_ref_q, var_uncal_q;
	logic save_armed_q;
	logic [1:0] ref_shown_q, ref_valid_q;
	copy_state_type copy_state_q;
	logic copy_slot_q;
	logic [AW-1:0] copy_idx_q;
	logic [15:0] ref_rd_q;
	logic [3:0] hscale_q, acq_vdiv_q, vdiv_q;
	logic hcompress_q, h_refused_q, v_refused_q;
	logic [7:0] ground_level_q;
	logic ground_stored_q, ground_refused_q;
	logic [16:0] volt_q;
	logic ratio_q;
	logic [31:0] time_q;

	////////////////////////////////////////////////////////////////////////
	// Bus slave: one wait state, writes need all byte lanes
	logic req, wr, limit_hit, start_ok, restart, we_acq, full;
	logic [31:0] rd_d, wd;
	logic [AW-1:0] waddr;
	logic [15:0] old_v, new_v;
	logic signed [16:0] diff, step, sum;

	assign req = wb_req.cyc & wb_req.stb & ~wb_rsp.ack;
	assign wr = req & wb_req.we & (wb_req.sel == 4'hf);
	assign wd = wb_req.dat;

	always_comb begin
		rd_d = 32'h0000_0000;
		case (wb_req.adr)
			ADDR_MODE: rd_d = {25'h0, time_recip_q, trig_place_q, 1'b0,
				acq_mode_q};
			ADDR_TRIG: rd_d = {trigger_index, trig_custom_q};
			ADDR_AVG: rd_d = {sweep_limit_q, 12'h000, weight_shift_q};
			ADDR_STATUS: rd_d = {8'h00, active_q, ref_valid_q, ref_shown_q,
				save_armed_q, copy_state_q, limit_hit, sweeps_done_q};
			ADDR_CURSOR: rd_d = {c1_q, c0_q};
			ADDR_REF_DATA: rd_d = {16'h0000, ref_rd_q};
			ADDR_SCALE: rd_d = {14'h0000, v_refused_q, h_refused_q, vdiv_q,
				acq_vdiv_q, 3'h0, hcompress_q, hscale_q};
			ADDR_GROUND: rd_d = {14'h0000, ground_refused_q, ground_stored_q,
				8'h00, ground_level_q};
			ADDR_READOUT: rd_d = {13'h0000, time_recip_q, ratio_q, volt_q};
			ADDR_TIME: rd_d = time_q;
			default: rd_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wb_rsp <= '0;
		end else begin
			wb_rsp.ack <= req;
			wb_rsp.dat <= req ? rd_d : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode, trigger and averaging settings
	assign restart = (wr && wb_req.adr == ADDR_CHANGE) ||
		(wr && wb_req.adr == ADDR_MODE && wd[2:0] != acq_mode_q &&
		wd[2:0] <= MODE_AVERAGE);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acq_mode_q <= MODE_SAMPLE;
			trig_place_q <= TRIG_LATE;
			time_recip_q <= 1'b0;
			trig_custom_q <= 16'h0000;
			weight_shift_q <= WEIGHT_SHIFT_RST;
			sweep_limit_q <= SWEEP_LIMIT_RST;
		end else if (wr) begin
			if (wb_req.adr == ADDR_MODE) begin
				if (wd[2:0] <= MODE_AVERAGE)
					acq_mode_q <= acq_mode_type'(wd[2:0]);
				if (wd[5:4] != 2'b11)
					trig_place_q <= trig_place_type'(wd[5:4]);
				time_recip_q <= wd[6];
			end
			if (wb_req.adr == ADDR_TRIG && wd[15:0] <= LAST_POS)
				trig_custom_q <= wd[15:0];
			if (wb_req.adr == ADDR_AVG) begin
				if (wd[3:0] >= WEIGHT_SHIFT_MIN && wd[3:0] <= WEIGHT_SHIFT_MAX)
					weight_shift_q <= wd[3:0];
				sweep_limit_q <= wd[31:16];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			trigger_index <= 16'h0000;
		else if (trig_place_q == TRIG_LATE)
			trigger_index <= LATE_POS;
		else if (trig_place_q == TRIG_EARLY)
			trigger_index <= EARLY_POS;
		else
			trigger_index <= trig_custom_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Acquisition path
	assign limit_hit = sweep_limit_q != 16'h0000 &&
		sweeps_done_q >= sweep_limit_q;
	assign start_ok = !(acq_mode_q == MODE_AVERAGE && limit_hit);
	assign we_acq = sample_in.valid && !restart &&
		(sample_in.first ? start_ok : sweep_active_q);
	assign waddr = sample_in.first ? '0 : idx_q + 1'b1;
	assign full = sample_in.first ? (sweeps_done_q == 16'h0000) :
		first_sweep_q;
	assign old_v = acq_mem[waddr];
	assign diff = $signed({sample_in.value[15], sample_in.value}) -
		$signed({old_v[15], old_v});
	assign step = diff >>> weight_shift_q;
	assign sum = $signed({old_v[15], old_v}) + step;

	always_comb begin
		case (acq_mode_q)
			MODE_PEAK_DET: new_v = sample_in.peak;
			MODE_ACC_PEAK: new_v = (full || $signed(sample_in.peak) >
				$signed(old_v)) ? sample_in.peak : old_v;
			// normalised average, first sweep at full amplitude
			MODE_AVERAGE: new_v = full ? sample_in.value : sum[15:0];
			default: new_v = sample_in.value;
		endcase
	end

	// stop adding at the limit or on restart
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sweeps_done_q <= 16'h0000;
			sweep_active_q <= 1'b0;
			first_sweep_q <= 1'b0;
			idx_q <= '0;
		end else if (restart) begin
			sweeps_done_q <= 16'h0000;
			sweep_active_q <= 1'b0;
		end else if (sample_in.valid) begin
			idx_q <= waddr;
			if (sample_in.first) begin
				sweep_active_q <= start_ok;
				first_sweep_q <= full;
				if (start_ok && sweeps_done_q != 16'hffff)
					sweeps_done_q <= sweeps_done_q + 16'h0001;
			end
		end
	end

	// record holds when no longer written
	always_ff @(posedge clock) begin
		if (we_acq)
			acq_mem[waddr] <= new_v;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			display_out <= '0;
		end else begin
			display_out.valid <= we_acq;
			display_out.index <= 16'(waddr);
			display_out.value <= new_v;
			display_out.ground_dot <= we_acq && ground_stored_q && waddr == '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reference save and recall
	logic press, slot;
	assign press = wr && wb_req.adr == ADDR_REF_CMD && wd[1:0] != 2'b00;
	assign slot = ~wd[0];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			save_armed_q <= 1'b0;
			ref_shown_q <= 2'b00;
			ref_valid_q <= 2'b00;
			copy_state_q <= COPY_IDLE;
			copy_slot_q <= 1'b0;
			copy_idx_q <= '0;
		end else begin
			// armed press saves, into pressed slot
			if (press && save_armed_q) begin
				if (copy_state_q == COPY_IDLE) begin
					copy_state_q <= COPY_RUN;
					copy_slot_q <= slot;
					copy_idx_q <= '0;
					save_armed_q <= 1'b0;
					ref_shown_q[slot] <= 1'b1;
				end
			end else if (press) begin
				ref_shown_q[slot] <= ~ref_shown_q[slot];
			end else if (wr && wb_req.adr == ADDR_REF_CMD && wd[2]) begin
				save_armed_q <= 1'b1;
			end
			if (copy_state_q == COPY_RUN) begin
				copy_idx_q <= copy_idx_q + 1'b1;
				if (copy_idx_q == AW'(RECORD_LEN - 1)) begin
					copy_state_q <= COPY_IDLE;
					ref_valid_q[copy_slot_q] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (copy_state_q == COPY_RUN)
			ref_mem[copy_slot_q][copy_idx_q] <= acq_mem[copy_idx_q];
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			ref_rd_q <= 16'h0000;
		else if (wr && wb_req.adr == ADDR_REF_DATA)
			ref_rd_q <= ref_mem[wd[16]][wd[AW-1:0]];
	end

	////////////////////////////////////////////////////////////////////////
	// Display rescaling
	logic h_ok, v_bad;
	logic [3:0] v_req, v_acq, v_dist;
	assign v_acq = wd[11:8];
	assign v_req = wd[15:12];
	assign v_dist = (v_req > v_acq) ? v_req - v_acq : v_acq - v_req;
	// cursor must sit on a shown reference
	assign h_ok = wd[3:0] != 4'h0 && wd[3:0] <= HSCALE_MAX && on_ref_q &&
		(ref_shown_q & ref_valid_q) != 2'b00;
	assign v_bad = v_acq > VDIV_LEAST || v_req > VDIV_LEAST ||
		v_dist > VSTEP_MAX ||
		(v_req < v_acq && v_acq == VDIV_MOST) ||
		(v_req > v_acq && v_acq == VDIV_LEAST);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hscale_q <= 4'h1;
			hcompress_q <= 1'b0;
			h_refused_q <= 1'b0;
			acq_vdiv_q <= VDIV_MOST;
			vdiv_q <= VDIV_MOST;
			v_refused_q <= 1'b0;
		end else if (wr && wb_req.adr == ADDR_SCALE) begin
			h_refused_q <= ~h_ok;
			if (h_ok) begin
				hscale_q <= wd[3:0];
				hcompress_q <= wd[4];
			end
			v_refused_q <= v_bad;
			if (!v_bad) begin
				acq_vdiv_q <= v_acq;
				vdiv_q <= v_req;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Ground reference capture
	logic g_win, g_coupled;
	assign g_win = $signed(wd[7:0]) <= GROUND_WINDOW &&
		$signed(wd[7:0]) >= -GROUND_WINDOW;
	assign g_coupled = wd[10] ? (wd[8] & wd[9]) : (wd[11] ? wd[9] : wd[8]);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ground_level_q <= 8'h00;
			ground_stored_q <= 1'b0;
			ground_refused_q <= 1'b0;
		end else if (wr && wb_req.adr == ADDR_GROUND && wd[12]) begin
			if (g_win && g_coupled) begin
				ground_level_q <= wd[7:0];
				ground_stored_q <= 1'b1;
				ground_refused_q <= 1'b0;
			end else begin
				ground_refused_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cursors and readouts
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			c0_q <= 16'h0000;
			c1_q <= LAST_POS;
			active_q <= 1'b0;
			on_ref_q <= 1'b0;
			var_uncal_q <= 1'b0;
		end else if (wr && wb_req.adr == ADDR_CURSOR) begin
			if (wd[16] && wd[15:0] <= LAST_POS) begin
				if (active_q)
					c1_q <= wd[15:0];
				else
					c0_q <= wd[15:0];
			end
			if (wd[17])
				active_q <= ~active_q;
			on_ref_q <= wd[18];
			var_uncal_q <= wd[19];
		end
	end

	logic [15:0] va, vr, dt;
	assign va = acq_mem[active_q ? c1_q[AW-1:0] : c0_q[AW-1:0]];
	assign vr = acq_mem[active_q ? c0_q[AW-1:0] : c1_q[AW-1:0]];
	assign dt = (c1_q > c0_q) ? c1_q - c0_q : c0_q - c1_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			volt_q <= 17'h00000;
			ratio_q <= 1'b0;
			time_q <= 32'h0000_0000;
		end else begin
			volt_q <= ($signed(va) >= $signed(vr)) ?
				17'($signed({va[15], va}) - $signed({vr[15], vr})) :
				17'($signed({vr[15], vr}) - $signed({va[15], va}));
			ratio_q <= var_uncal_q;
			if (!time_recip_q)
				time_q <= {16'h0000, dt};
			else
				time_q <= (dt == 16'h0000) ? 32'h0000_0000 :
					RECIP_NUM / {16'h0000, dt};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	chk_trig_late_place: assert property (
		trig_place_q == TRIG_LATE ##1 trig_place_q == TRIG_LATE |->
		trigger_index == LATE_POS) else $error("late trigger misplaced");
	chk_trig_custom_pos: assert property (
		trig_place_q == TRIG_CUSTOM |=> trigger_index == $past(trig_custom_q))
		else $error("custom trigger misplaced");
	chk_weight_range: assert property (
		weight_shift_q >= WEIGHT_SHIFT_MIN && weight_shift_q <= WEIGHT_SHIFT_MAX)
		else $error("weight outside range");
	chk_avg_limit_stop: assert property (
		acq_mode_q == MODE_AVERAGE && limit_hit && sample_in.valid &&
		sample_in.first |=> !sweep_active_q && !display_out.valid)
		else $error("averaging past sweep limit");
	chk_restart_full_amp: assert property (
		restart |=> sweeps_done_q == 16'h0000 && !sweep_active_q)
		else $error("restart did not clear average");
	chk_cursor_swap: assert property (
		wr && wb_req.adr == ADDR_CURSOR && wd[17] |=>
		active_q != $past(active_q) ##1 wb_rsp.ack == 1'b0)
		else $error("cursor select failed");
	chk_ground_window: assert property (
		wr && wb_req.adr == ADDR_GROUND && wd[12] && !g_win |=>
		$stable(ground_level_q) && ground_refused_q)
		else $error("ground captured out of window");
	chk_vert_end_stop: assert property (
		wr && wb_req.adr == ADDR_SCALE && v_acq == VDIV_LEAST &&
		v_req > v_acq |=> v_refused_q && $stable(vdiv_q))
		else $error("compress allowed at least sensitive");
	chk_save_slot: assert property (
		press && save_armed_q && copy_state_q == COPY_IDLE |=>
		copy_state_q == COPY_RUN && !save_armed_q)
		else $error("armed press did not save");
endmodule // waveform_store_average_cursor

//--- sim/sweep_source.sv
// Channel sample source standing in for the sampled vertical inputs
`timescale 1ns/10ps
module sweep_source #(
	parameter int RECORD_LEN = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [15:0] level,
	input wire logic slow,
	output waveform_store_pkg::sample_type sample,
	output logic busy
);
	import waveform_store_pkg::*;
	logic run_q;
	logic gap_q;
	logic [15:0] idx_q;
	////////////////////////////////////////////////////////////////////////
	// One sweep per go pulse, value level+index; slow leaves idle gaps
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			gap_q <= 1'b0;
			idx_q <= 16'h0000;
			sample <= '0;
		end else begin
			gap_q <= ~gap_q;
			if (go) begin
				run_q <= 1'b1;
				idx_q <= 16'h0000;
				sample.valid <= 1'b0;
			end else if (run_q && (!slow || gap_q)) begin
				sample <= '{1'b1, idx_q == 16'h0000, level + idx_q,
					level + idx_q + 16'h0100};
				idx_q <= idx_q + 16'h0001;
				if (idx_q == 16'(RECORD_LEN - 1)) begin
					run_q <= 1'b0;
				end
			end else begin
				// Idle lines invert every cycle, so the last value returns every other cycle
				sample <= '{1'b0, 1'b0, ~sample.value, ~sample.peak};
			end
		end
	end
	assign busy = run_q | sample.valid;
endmodule // sweep_source

//--- sim/waveform_store_average_cursor_tb.sv
// Self-checking bench for the waveform store block
`timescale 1ns/10ps
module waveform_store_average_cursor_tb;
	import waveform_store_pkg::*;
	logic clock;
	logic rst_n;
	wb_req_type wb_req;
	wb_rsp_type wb_rsp;
	sample_type sample;
	display_type display_out;
	logic [15:0] trigger_index;
	logic go;
	logic slow;
	logic busy;
	logic [15:0] level;
	logic [15:0] exp_base;
	logic dot_seen;
	logic [31:0] r;
	int n_disp;
	int n_fail;
	int tests_run;

	waveform_store_average_cursor #(.RECORD_LEN(16)) dut (
		.clock(clock), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
		.sample_in(sample), .display_out(display_out),
		.trigger_index(trigger_index));
	sweep_source #(.RECORD_LEN(16)) src (
		.clock(clock), .rst_n(rst_n), .go(go), .level(level),
		.slow(slow), .sample(sample), .busy(busy));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////
	task give_verdict;
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Classic single cycle; answer taken at the edge where ack is seen
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 50);
		r = wb_rsp.dat;
		wb_req <= '0;
		if (n >= 50) begin
			check(1'b0, 1'b1, "bus timeout");
			give_verdict();
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(r & m, e, "register read");
	endtask
	task trig(input logic [15:0] e);
		repeat (3) @(posedge clock);
		check({16'h0, trigger_index}, {16'h0, e}, "trigger position");
	endtask
	task sweep(input logic [15:0] lv, input logic [15:0] base, input int ne,
		input logic sl);
		int n;
		exp_base = base;
		n_disp = 0;
		@(posedge clock);
		level <= lv;
		slow <= sl;
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (busy && n < 200);
		if (n >= 200) begin
			check(1'b0, 1'b1, "sweep timeout");
			give_verdict();
		end
		repeat (3) @(posedge clock);
		check(32'(n_disp), 32'(ne), "display count");
	endtask
	// Every stored point must equal the expected record value
	always @(posedge clock) begin
		if (display_out.valid === 1'b1) begin
			n_disp++;
			if (display_out.index === 16'h0000)
				dot_seen = display_out.ground_dot;
			check({16'h0, display_out.value},
				{16'h0, exp_base + display_out.index}, "stored point");
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		int n;
		n_fail = 0;
		tests_run = 0;
		rst_n = 1'b0;
		wb_req = '0;
		go = 1'b0;
		slow = 1'b0;
		level = 16'h0000;
		exp_base = 16'h0000;
		dot_seen = 1'b0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		trig(16'h000e);
		rd(ADDR_AVG, 32'hffff000f, 32'h00000002);
		rd(ADDR_TIME, 32'hffffffff, 32'h0000000f);
		rd(8'h30, 32'hffffffff, 32'h0); // unmapped place
		wr(ADDR_MODE, 32'h10);
		trig(16'h0002);
		wr(ADDR_TRIG, 32'h5);
		wr(ADDR_MODE, 32'h20);
		trig(16'h0005);
		wr(ADDR_TRIG, 32'h10);
		trig(16'h0005);
		for (int m = 1; m <= 2; m++) begin
			wr(ADDR_MODE, 32'(m));
			rd(ADDR_MODE, 32'h7, 32'(m));
			sweep(16'h0100, 16'h0200, 16, 1'b0);
			sweep(16'h0050, (m == 1) ? 16'h0200 : 16'h0150, 16,
				1'b0);
		end
		wr(ADDR_AVG, 32'h00020000);
		rd(ADDR_AVG, 32'hffff000f, 32'h00020002);
		wr(ADDR_AVG, 32'h00020009);
		rd(ADDR_AVG, 32'hffff000f, 32'h00020002);
		wr(ADDR_AVG, 32'h00020001);
		rd(ADDR_AVG, 32'hffff000f, 32'h00020001);
		// Average of two sweeps at weight one half, then the limit
		wr(ADDR_MODE, 32'h3);
		sweep(16'h0100, 16'h0100, 16, 1'b0);
		sweep(16'h0300, 16'h0200, 16, 1'b1);
		rd(ADDR_STATUS, 32'h1ffff, 32'h10002);
		sweep(16'h0700, 16'h0200, 0, 1'b0);
		rd(ADDR_STATUS, 32'h1ffff, 32'h10002);
		wr(ADDR_CHANGE, 32'h1);
		repeat (2) @(posedge clock);
		sweep(16'h0500, 16'h0500, 16, 1'b0);
		wr(ADDR_MODE, 32'h0);
		// Ground capture window and summed-mode coupling
		wr(ADDR_GROUND, 32'h1133);
		rd(ADDR_GROUND, 32'h300ff, 32'h20000);
		wr(ADDR_GROUND, 32'h15ce);
		rd(ADDR_GROUND, 32'h300ff, 32'h20000);
		wr(ADDR_GROUND, 32'h1732);
		rd(ADDR_GROUND, 32'h300ff, 32'h10032);
		sweep(16'h0040, 16'h0040, 16, 1'b1);
		check(32'(dot_seen), 32'h1, "ground dot");
		// Cursors and readouts over a record of 0x40 plus index
		rd(ADDR_READOUT, 32'h7ffff, 32'h0000f);
		wr(ADDR_CURSOR, 32'h20000);
		rd(ADDR_STATUS, 32'h800000, 32'h800000);
		wr(ADDR_CURSOR, 32'h10004);
		rd(ADDR_CURSOR, 32'hffffffff, 32'h00040000);
		rd(ADDR_READOUT, 32'h7ffff, 32'h00004);
		wr(ADDR_MODE, 32'h40);
		rd(ADDR_TIME, 32'hffffffff, 32'h0003d090);
		wr(ADDR_CURSOR, 32'h80000);
		rd(ADDR_READOUT, 32'h20000, 32'h20000);
		// Horizontal and vertical rescaling limits
		wr(ADDR_SCALE, 32'h0552);
		rd(ADDR_SCALE, 32'h10000, 32'h10000);
		wr(ADDR_CURSOR, 32'h40000);
		// No reference is shown yet, so the factor is still refused
		wr(ADDR_SCALE, 32'h055a);
		rd(ADDR_SCALE, 32'h10000, 32'h10000);
		wr(ADDR_SCALE, 32'hba01);
		rd(ADDR_SCALE, 32'h20000, 32'h20000);
		wr(ADDR_SCALE, 32'h0a01);
		rd(ADDR_SCALE, 32'h20000, 32'h20000);
		wr(ADDR_SCALE, 32'h4501);
		rd(ADDR_SCALE, 32'h20000, 32'h0);
		// Save into slot 1, then toggle its display off without overwriting
		wr(ADDR_REF_CMD, 32'h4);
		rd(ADDR_STATUS, 32'h40000, 32'h40000);
		wr(ADDR_REF_CMD, 32'h2);
		n = 0;
		do begin
			wb(1'b0, ADDR_STATUS, 32'h0);
			n++;
		end while (r[17] !== 1'b0 && n < 100);
		if (n >= 100) begin
			check(1'b0, 1'b1, "copy timeout");
			give_verdict();
		end
		check({30'h0, r[22:21]}, 32'h2, "reference slot");
		wr(ADDR_REF_DATA, 32'h10003);
		rd(ADDR_REF_DATA, 32'hffff, 32'h0043);
		wr(ADDR_SCALE, 32'h055a);
		rd(ADDR_SCALE, 32'h10000, 32'h0);
		sweep(16'h0200, 16'h0200, 16, 1'b0);
		wr(ADDR_REF_CMD, 32'h2);
		repeat (40) @(posedge clock);
		rd(ADDR_STATUS, 32'h100000, 32'h0);
		wr(ADDR_REF_DATA, 32'h10003);
		rd(ADDR_REF_DATA, 32'hffff, 32'h0043);
		give_verdict();
	end
endmodule // waveform_store_average_cursor_tb
